// ==== stl_pkg.sv ====
/*
  stl_pkg: constants and types shared by the status lamp block.
  assumes: mclk at 125 MHz, registers on AXI4-Lite with 32-bit data.
*/
package stl_pkg;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8; // decoded address bits
  localparam int DATA_W = 32; // bus data width
  localparam logic [7:0] REG_CTRL = 8'h00; // control bits
  localparam logic [7:0] REG_STEP = 8'h04; // test step strobes
  localparam logic [7:0] REG_RUN = 8'h08; // run-state code
  localparam logic [7:0] REG_STAT = 8'h0c; // block status
  localparam logic [7:0] REG_IRQ = 8'h10; // sticky events, read clears
  localparam logic [7:0] REG_MASK = 8'h14; // event mask
  localparam logic [1:0] RESP_OKAY = 2'h0; // good answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTL_W = 4; // control width
  localparam int CTL_TESTS = 0; // run self-tests
  localparam int CTL_LOOP = 1; // loopback tests too
  localparam int CTL_FATAL = 2; // i/o page registers unreachable
  localparam int CTL_JUMPER = 3; // power-up jumper inhibits tests
  localparam logic [3:0] CTL_RST = 4'h1; // tests on after reset
  localparam int STEP_FAIL = 3; // step: named test failed
  localparam int STEP_PASS = 4; // step: named test passed
  localparam int IRQ_W = 4; // number of events
  localparam int IRQ_CHECK = 0; // lamp check over
  localparam int IRQ_FAIL = 1; // a self-test failed
  localparam int IRQ_PASS = 2; // all self-tests passed
  localparam int IRQ_FATAL = 3; // fatal indication entered
  // ----------------------------------------------------------------
  // lamp codes, lit = 1
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_ALL_ON = 3'h7; // every code lamp lit
  localparam logic [2:0] CODE_AUTO = 3'h7; // automatic self-tests
  localparam logic [2:0] CODE_LOOP = 3'h6; // loopback plus automatic
  localparam logic [2:0] CODE_DEBUG = 3'h5; // bus-side debug monitor
  localparam logic [2:0] CODE_UNUSED = 3'h4; // never shown as a run-state code
  localparam logic [2:0] CODE_WAIT = 3'h3; // waiting for command
  localparam logic [2:0] CODE_LOAD = 3'h2; // host down-line load
  localparam logic [2:0] CODE_TAPE = 3'h1; // tape primary bootstrap
  localparam logic [2:0] CODE_FOREIGN = 3'h0; // non-native code
  // ----------------------------------------------------------------
  // self-test order, index equals failure code
  // ----------------------------------------------------------------
  localparam logic [2:0] T_DMA_RTC = 3'h0;
  localparam logic [2:0] T_RAM = 3'h1;
  localparam logic [2:0] T_ROM = 3'h2;
  localparam logic [2:0] T_CONSOLE = 3'h3;
  localparam logic [2:0] T_CHAN_A = 3'h4;
  localparam logic [2:0] T_CHAN_B = 3'h5;
  localparam logic [2:0] T_PARALLEL = 3'h6;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8; // mclk period
  localparam int unsigned LAMP_CHECK_MS = 500; // lamp check time
  localparam int unsigned LAMP_CHECK_CYC = LAMP_CHECK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int LAMP_CNT_W = 26; // holds LAMP_CHECK_CYC
  // phases of the restart sequence
  typedef enum logic [4:0] {
    ST_CHECK = 5'h01,
    ST_TEST = 5'h02,
    ST_FAIL = 5'h04,
    ST_FATAL = 5'h08,
    ST_RUN = 5'h10
  } stl_phase_type;
endpackage : stl_pkg

// ==== stl_lamp_if.sv ====
/*
  stl_lamp_if: sequence state handed from control to lamp driver.
  assumes: both ends in the mclk domain.
*/
`timescale 1ns/100ps
interface stl_lamp_if;
  stl_pkg::stl_phase_type phase; // current phase
  logic [2:0] fail_code; // held failing test
  logic [2:0] run_code; // execution state
  logic loopback; // loopback tests selected
  modport ctl (output phase, fail_code, run_code, loopback);
  modport drv (input phase, fail_code, run_code, loopback);
endinterface : stl_lamp_if

// ==== stl_sticky.sv ====
/*
  stl_sticky: bank of sticky event flags, set wins over clear.
  assumes: synchronous set and clear pulses.
*/
`timescale 1ns/100ps
module stl_sticky #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] set,
  input wire logic clr,
  output logic [W-1:0] flags_q
);
  // an event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else if (ce) begin
      flags_q <= set | (clr ? '0 : flags_q);
    end
  end
endmodule : stl_sticky

// ==== stl_lamp_drv.sv ====
/*
  stl_lamp_drv: turns sequence state into the four lamp levels.
  assumes: lamp state comes from flops in the same clock domain.
*/
`timescale 1ns/100ps
module stl_lamp_drv (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  stl_lamp_if.drv lamp,
  output logic err_q,
  output logic [2:0] code_q
);
  // phase decode
  wire logic in_chk = lamp.phase == stl_pkg::ST_CHECK;
  wire logic in_fatal = lamp.phase == stl_pkg::ST_FATAL;
  wire logic in_fail = lamp.phase == stl_pkg::ST_FAIL;
  wire logic in_test = lamp.phase == stl_pkg::ST_TEST;
  wire logic all_on = in_chk | in_fatal;
  wire logic [2:0] test_code = lamp.loopback ? stl_pkg::CODE_LOOP : stl_pkg::CODE_AUTO;
  wire logic err_d = all_on | in_fail;
  wire logic [2:0] code_d = all_on ? stl_pkg::CODE_ALL_ON :
                            in_fail ? lamp.fail_code :
                            in_test ? test_code : lamp.run_code;
  // lamps come straight from these flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      err_q <= 1'b1;
      code_q <= stl_pkg::CODE_ALL_ON;
    end else if (ce) begin
      err_q <= err_d;
      code_q <= code_d;
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_all_lit: assert property (ce && all_on |=> err_q && code_q == stl_pkg::CODE_ALL_ON) // (R1) (R9)
    else $error("all lamps not lit");
  a_test_code: assert property (ce && in_test |=> !err_q && code_q == $past(test_code)) // (R2) (R12)
    else $error("wrong test lamps");
  a_fail_code: assert property (ce && in_fail |=> err_q && code_q == $past(lamp.fail_code)) // (R3) (R5) (R6) (R7) (R8)
    else $error("failure code not shown");
  a_run_code: assert property (ce && lamp.phase == stl_pkg::ST_RUN |=> !err_q && code_q != stl_pkg::CODE_UNUSED) // (R10) (R11) (R13) (R14)
    else $error("bad run lamps");
endmodule : stl_lamp_drv

// ==== stl_top.sv ====
/*
  stl_top: status lamp sequencer of a board's restart and self-test.
  assumes: firmware reports test steps and run state over AXI4-Lite;
  reinit is a synchronous level, ce freezes all state when low.
*/
// Behaviour
// (R1) all four lamps lit half second
// (R2) tests running: error dark, codes lit
// (R3) test failure lights error, shows test
// (R4) tests run in fixed failure-code order
// (R5) codes 000 dma/clock, 001 ram
// (R6) code 010 rom checksum failure
// (R7) code 011 console serial line failure
// (R8) codes 100, 101, 110 channels, parallel
// (R9) fatal or jumper inhibit: all lit
// (R10) all pass: boot, codes show state
// (R11) tests skipped: error dark, state codes
// (R12) 111 automatic, 110 with loopback
// (R13) 101 debug monitor, 100 unused
// (R14) 011 wait, 010 load, 001 tape, 000 foreign
// (R15) failure code held until next restart
`timescale 1ns/100ps
module stl_top #(
  parameter int unsigned LAMP_CYCLES = stl_pkg::LAMP_CHECK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic reinit,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic error_lamp,
  output logic code_lamp_high,
  output logic code_lamp_mid,
  output logic code_lamp_low,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  stl_pkg::stl_phase_type phase_q; // restart phase
  stl_pkg::stl_phase_type phase_d;
  logic [stl_pkg::LAMP_CNT_W-1:0] cnt_q; // lamp check timer
  logic [stl_pkg::LAMP_CNT_W-1:0] cnt_d;
  logic [2:0] next_q; // next test expected
  logic [2:0] next_d;
  logic [2:0] fail_q; // held failure code
  logic [2:0] fail_d;
  logic [stl_pkg::CTL_W-1:0] ctrl_q; // control register
  logic [2:0] run_q; // run-state code
  logic [stl_pkg::IRQ_W-1:0] mask_q; // event mask
  logic [stl_pkg::IRQ_W-1:0] stat_q; // sticky events
  logic irq_q; // interrupt level
  logic awready_q; // address slot empty
  logic wready_q; // data slot empty
  logic [7:0] wa_q; // held write address
  logic [31:0] wd_q; // held write data
  logic [3:0] ws_q; // held byte strobes
  logic bvalid_q; // write answer pending
  logic [1:0] bresp_q;
  logic arready_q; // read slot empty
  logic rvalid_q; // read answer pending
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic err_q; // lamp flops in the driver
  logic [2:0] code_q;
  logic [31:0] rd_mux; // read data select
  logic rd_hit; // read address mapped
  // ----------------------------------------------------------------
  // bus handshakes and decode
  // ----------------------------------------------------------------
  wire logic aw_hs = s_axi_awvalid & awready_q;
  wire logic w_hs = s_axi_wvalid & wready_q;
  wire logic ar_hs = s_axi_arvalid & arready_q;
  wire logic r_hs = rvalid_q & s_axi_rready;
  wire logic b_hs = bvalid_q & s_axi_bready;
  // both halves held and no answer outstanding
  wire logic do_wr = !awready_q & !wready_q & !bvalid_q;
  wire logic lo_en = ws_q[0]; // fields live in byte lane 0
  wire logic wr_ctrl = do_wr & lo_en & (wa_q == stl_pkg::REG_CTRL);
  wire logic wr_step = do_wr & lo_en & (wa_q == stl_pkg::REG_STEP);
  wire logic wr_run = do_wr & lo_en & (wa_q == stl_pkg::REG_RUN);
  wire logic wr_mask = do_wr & lo_en & (wa_q == stl_pkg::REG_MASK);
  wire logic wr_hit = (wa_q == stl_pkg::REG_CTRL) | (wa_q == stl_pkg::REG_STEP) |
                      (wa_q == stl_pkg::REG_RUN) | (wa_q == stl_pkg::REG_STAT) |
                      (wa_q == stl_pkg::REG_IRQ) | (wa_q == stl_pkg::REG_MASK);
  // codes reserved for test display or unused are refused
  wire logic run_ok = (wd_q[2:0] != stl_pkg::CODE_UNUSED) &
                      (wd_q[2:0] < stl_pkg::CODE_LOOP);
  wire logic irq_clr = ar_hs & (s_axi_araddr == stl_pkg::REG_IRQ);
  // step report fields
  wire logic [2:0] step_id = wd_q[2:0];
  wire logic step_fail = wr_step & wd_q[stl_pkg::STEP_FAIL];
  wire logic step_pass = wr_step & wd_q[stl_pkg::STEP_PASS] & !wd_q[stl_pkg::STEP_FAIL];
  wire logic in_order = step_id == next_q;
  // ----------------------------------------------------------------
  // sequence decode
  // ----------------------------------------------------------------
  wire logic chk_done = cnt_q == stl_pkg::LAMP_CNT_W'(LAMP_CYCLES - 1);
  wire logic fatal_in = ctrl_q[stl_pkg::CTL_FATAL] | ctrl_q[stl_pkg::CTL_JUMPER];
  wire logic [stl_pkg::IRQ_W-1:0] ev;
  assign ev[stl_pkg::IRQ_CHECK] = (phase_q == stl_pkg::ST_CHECK) & (phase_d != stl_pkg::ST_CHECK);
  assign ev[stl_pkg::IRQ_FAIL] = (phase_q == stl_pkg::ST_TEST) & (phase_d == stl_pkg::ST_FAIL);
  assign ev[stl_pkg::IRQ_PASS] = (phase_q == stl_pkg::ST_TEST) & (phase_d == stl_pkg::ST_RUN);
  assign ev[stl_pkg::IRQ_FATAL] = (phase_q != stl_pkg::ST_FATAL) & (phase_d == stl_pkg::ST_FATAL);
  // next phase, timer, test index and failure code
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    next_d = next_q;
    fail_d = fail_q;
    case (phase_q)
      stl_pkg::ST_CHECK: begin
        // all lamps lit until the timer ends
        cnt_d = cnt_q + 1'b1; // (R1)
        if (chk_done) begin
          cnt_d = '0;
          if (fatal_in) begin
            phase_d = stl_pkg::ST_FATAL; // (R9)
          end else if (ctrl_q[stl_pkg::CTL_TESTS]) begin
            phase_d = stl_pkg::ST_TEST; // (R2)
          end else begin
            phase_d = stl_pkg::ST_RUN; // (R11)
          end
        end
      end
      stl_pkg::ST_TEST: begin
        // only the expected test may report
        if (ctrl_q[stl_pkg::CTL_FATAL]) begin
          phase_d = stl_pkg::ST_FATAL; // (R9)
        end else if (step_fail && in_order) begin
          phase_d = stl_pkg::ST_FAIL; // (R3)
          fail_d = next_q; // (R4) (R5) (R6) (R7) (R8)
        end else if (step_pass && in_order) begin
          next_d = next_q + 3'h1; // (R4)
          if (next_q == stl_pkg::T_PARALLEL) begin
            phase_d = stl_pkg::ST_RUN; // (R10)
          end
        end
      end
      stl_pkg::ST_FAIL: begin
        // failure code stays until restart
        phase_d = stl_pkg::ST_FAIL; // (R15)
      end
      stl_pkg::ST_FATAL: begin
        phase_d = stl_pkg::ST_FATAL; // (R9)
      end
      stl_pkg::ST_RUN: begin
        // a later fault still shows as fatal
        if (ctrl_q[stl_pkg::CTL_FATAL]) begin
          phase_d = stl_pkg::ST_FATAL;
        end
      end
      default: begin
        phase_d = stl_pkg::ST_CHECK;
      end
    endcase
    // reinitialization restarts the lamp check
    if (reinit) begin
      phase_d = stl_pkg::ST_CHECK; // (R1) (R15)
      cnt_d = '0;
      next_d = stl_pkg::T_DMA_RTC;
      fail_d = '0;
    end
  end
  // sequence flops
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= stl_pkg::ST_CHECK;
      cnt_q <= '0;
      next_q <= stl_pkg::T_DMA_RTC;
      fail_q <= '0;
    end else if (ce) begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      next_q <= next_d;
      fail_q <= fail_d;
    end
  end
  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= stl_pkg::CTL_RST;
      run_q <= stl_pkg::CODE_WAIT;
      mask_q <= '0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= wd_q[stl_pkg::CTL_W-1:0];
      end
      if (wr_run && run_ok) begin
        run_q <= wd_q[2:0]; // (R13) (R14)
      end
      if (wr_mask) begin
        mask_q <= wd_q[stl_pkg::IRQ_W-1:0];
      end
    end
  end
  // sticky events, cleared by a read of the event register
  stl_sticky #(
    .W(stl_pkg::IRQ_W)
  ) u_events (
    .clk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .set(ev & {stl_pkg::IRQ_W{ce}}),
    .clr(irq_clr),
    .flags_q(stat_q)
  );
  // interrupt level while an unmasked event is held
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |(stat_q & mask_q);
    end
  end
  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      wa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= stl_pkg::RESP_OKAY;
    end else if (ce) begin
      // address and data taken in either order
      if (aw_hs) begin
        awready_q <= 1'b0;
        wa_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      // answer once both are held
      if (do_wr) begin
        awready_q <= 1'b1;
        wready_q <= 1'b1;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? stl_pkg::RESP_OKAY : stl_pkg::RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  // read data select, unmapped reads as zero with an error
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == stl_pkg::REG_CTRL) begin
      rd_mux = {28'h0, ctrl_q};
    end else if (s_axi_araddr == stl_pkg::REG_STEP) begin
      rd_mux = {29'h0, next_q};
    end else if (s_axi_araddr == stl_pkg::REG_RUN) begin
      rd_mux = {29'h0, run_q};
    end else if (s_axi_araddr == stl_pkg::REG_STAT) begin
      rd_mux = {19'h0, phase_q, err_q, code_q, 1'b0, fail_q};
    end else if (s_axi_araddr == stl_pkg::REG_IRQ) begin
      rd_mux = {28'h0, stat_q};
    end else if (s_axi_araddr == stl_pkg::REG_MASK) begin
      rd_mux = {28'h0, mask_q};
    end else begin
      rd_hit = 1'b0;
    end
  end
  // one read at a time
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= stl_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_hit ? stl_pkg::RESP_OKAY : stl_pkg::RESP_SLVERR;
      end else if (r_hs) begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // lamp driver
  // ----------------------------------------------------------------
  stl_lamp_if u_lamp_if ();
  assign u_lamp_if.phase = phase_q;
  assign u_lamp_if.fail_code = fail_q;
  assign u_lamp_if.run_code = run_q;
  assign u_lamp_if.loopback = ctrl_q[stl_pkg::CTL_LOOP]; // (R12)
  stl_lamp_drv u_drv (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .lamp(u_lamp_if.drv),
    .err_q(err_q),
    .code_q(code_q)
  );
  // ports straight from flops
  assign error_lamp = err_q;
  assign code_lamp_high = code_q[2];
  assign code_lamp_mid = code_q[1];
  assign code_lamp_low = code_q[0];
  assign irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic go = ce & !reinit;
  sequence s_good_fail;
    go && phase_q == stl_pkg::ST_TEST && !ctrl_q[stl_pkg::CTL_FATAL] && step_fail && in_order;
  endsequence
  a_check_hold: assert property (go && phase_q == stl_pkg::ST_CHECK && !chk_done |=> phase_q == stl_pkg::ST_CHECK) // (R1)
    else $error("lamp check ended early");
  a_check_end: assert property (go && phase_q == stl_pkg::ST_CHECK && chk_done |=> phase_q != stl_pkg::ST_CHECK) // (R1)
    else $error("lamp check overran");
  a_fail_latch: assert property (s_good_fail |=> phase_q == stl_pkg::ST_FAIL && fail_q == $past(next_q)) // (R3)
    else $error("failure not latched");
  a_order_kept: assert property (go && phase_q == stl_pkg::ST_TEST && !ctrl_q[stl_pkg::CTL_FATAL] && wr_step && !in_order |=> phase_q == stl_pkg::ST_TEST && $stable(next_q)) // (R4)
    else $error("out of order step taken");
  a_fail_hold: assert property (phase_q == stl_pkg::ST_FAIL && !reinit |=> phase_q == stl_pkg::ST_FAIL && $stable(fail_q)) // (R15)
    else $error("failure code lost");
  a_fatal_entry: assert property (go && phase_q == stl_pkg::ST_CHECK && chk_done && fatal_in |=> phase_q == stl_pkg::ST_FATAL) // (R9)
    else $error("fatal not entered");
  a_skip_tests: assert property (go && phase_q == stl_pkg::ST_CHECK && chk_done && !fatal_in && !ctrl_q[stl_pkg::CTL_TESTS] |=> phase_q == stl_pkg::ST_RUN) // (R11)
    else $error("skipped tests not honoured");
  a_boot_after: assert property (go && phase_q == stl_pkg::ST_TEST && !ctrl_q[stl_pkg::CTL_FATAL] && step_pass && in_order && next_q == stl_pkg::T_PARALLEL |=> phase_q == stl_pkg::ST_RUN ##1 !error_lamp) // (R10)
    else $error("no boot after last pass");
  a_irq_level: assert property (ce && |(stat_q & mask_q) |=> irq) else $error("interrupt missing");
endmodule : stl_top

// ==== stl_lamp_model.sv ====
/*
  stl_lamp_model: the four board-edge status lamps as a viewer sees them.
  assumes: lamp inputs are high while the lamp is lit.
*/
`timescale 1ns/100ps
module stl_lamp_model (
  input wire logic error_lamp,
  input wire logic code_lamp_high,
  input wire logic code_lamp_mid,
  input wire logic code_lamp_low,
  output logic [3:0] lit
);
  // pattern left to right, error lamp first, lit = 1
  assign lit = {error_lamp, code_lamp_high, code_lamp_mid, code_lamp_low};
endmodule : stl_lamp_model

// ==== tb.sv ====
/*
  tb: register-driven bench for the status lamp sequencer.
  assumes: stl_top with a shortened lamp check, lamps read through stl_lamp_model.
*/
`timescale 1ns/100ps
module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int LC = 16; // shortened lamp check length
  logic mclk, rst_b, ce, reinit, irq, el, ch, cm, cl;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_q, e_q;
  logic [3:0] wstrb, lit;
  logic [1:0] bresp, rresp, rs_q;
  int fail_count, total_checks;
  stl_top #(.LAMP_CYCLES(LC)) uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .reinit(reinit),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .error_lamp(el), .code_lamp_high(ch), .code_lamp_mid(cm), .code_lamp_low(cl), .irq(irq));
  stl_lamp_model lamps (.error_lamp(el), .code_lamp_high(ch), .code_lamp_mid(cm),
    .code_lamp_low(cl), .lit(lit));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // bus write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1;
        rs_q = bresp;
      end
    end
    bready <= 1'b0;
    if (!done) begin
      fail_count++;
      close_out;
    end
  endtask : wr
  // bus read: data and response kept in rd_q and rs_q
  task automatic rd(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1;
        rd_q = rdata;
        rs_q = rresp;
      end
    end
    rready <= 1'b0;
    if (!done) begin
      fail_count++;
      close_out;
    end
  endtask : rd
  // lamp pattern after a few settling edges
  task automatic see(input logic [31:0] e);
    repeat (2) @(posedge mclk);
    #1 chk({28'h0, lit}, e);
  endtask : see
  // set control, pulse reinit, watch the lamp check end on its count
  task automatic restart(input logic [31:0] c, input logic [31:0] e);
    wr(stl_pkg::REG_CTRL, c);
    reinit <= 1'b1;
    @(posedge mclk);
    reinit <= 1'b0;
    // last lit edge of the check, then the new pattern one edge later
    repeat (LC) @(posedge mclk);
    #1 chk({28'h0, lit}, 32'hf);
    @(posedge mclk);
    #1 chk({28'h0, lit}, e);
  endtask : restart
  // ------------------------------------------------------------
  // clock and sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    {rst_b, reinit, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    ce = 1'b1;
    wstrb = 4'hf;
    fail_count = 0;
    total_checks = 0;
    repeat (3) @(posedge mclk);
    chk({28'h0, lit}, 32'hf);
    rst_b <= 1'b1;
    // reset values and unmapped places
    rd(stl_pkg::REG_CTRL);
    chk(rd_q, 32'h1);
    rd(stl_pkg::REG_RUN);
    chk(rd_q, 32'h3);
    rd(8'h20);
    chk({rs_q, rd_q[29:0]}, 32'h80000000);
    wr(8'h24, 32'h1);
    chk({30'h0, rs_q}, 32'h2);
    // interrupt masked, raised, cleared by reading
    wr(stl_pkg::REG_MASK, 32'h0);
    restart(32'h1, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(stl_pkg::REG_MASK, 32'h1);
    restart(32'h1, 32'h7);
    chk({31'h0, irq}, 32'h1);
    rd(stl_pkg::REG_IRQ);
    chk(rd_q, 32'h1);
    see(32'h7);
    chk({31'h0, irq}, 32'h0);
    // each test fails in turn after the earlier ones pass
    for (int k = 0; k < 7; k++) begin
      restart(32'h1, 32'h7);
      for (int i = 0; i < k; i++) wr(stl_pkg::REG_STEP, 32'h10 | i);
      rd(stl_pkg::REG_STEP);
      chk(rd_q, 32'(k));
      if (k < 6) wr(stl_pkg::REG_STEP, 32'h08 | (k + 1));
      see(32'h7);
      wr(stl_pkg::REG_STEP, 32'h08 | k);
      see(32'h8 + k);
      wr(stl_pkg::REG_CTRL, 32'h5);
      see(32'h8 + k);
      rd(stl_pkg::REG_STAT);
      chk(rd_q, 32'h480 | (k << 4) | k);
    end
    // all pass, then every run code
    restart(32'h1, 32'h7);
    for (int i = 0; i < 7; i++) wr(stl_pkg::REG_STEP, 32'h10 | i);
    see(32'h3);
    e_q = 32'h3;
    for (int c = 0; c < 8; c++) begin
      wr(stl_pkg::REG_RUN, 32'(c));
      if (c != 4 && c < 6) e_q = 32'(c);
      see(e_q);
    end
    wr(stl_pkg::REG_CTRL, 32'h5);
    see(32'hf);
    restart(32'h3, 32'h6);
    restart(32'h0, 32'h5);
    // clock enable low freezes the sequence, reinit included
    @(posedge mclk);
    ce <= 1'b0;
    reinit <= 1'b1;
    see(32'h5);
    @(posedge mclk);
    ce <= 1'b1;
    see(32'hf);
    @(posedge mclk);
    reinit <= 1'b0;
    restart(32'h8, 32'hf);
    restart(32'h4, 32'hf);
    // every event kind has happened since the last clearing read
    rd(stl_pkg::REG_IRQ);
    chk(rd_q, 32'hf);
    close_out;
  end
endmodule : tb
